// *** common/swm_pkg.sv ***
package swm_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_MHZ = 125;
    localparam int RESET_LOW_TIME_US = 480;
    localparam int RESET_HIGH_TIME_US = 480;
    localparam int PRESENCE_SAMPLE_US = 70;
    localparam int SLOT_LENGTH_US = 70;
    localparam int WRITE_ZERO_LOW_TIME_US = 60;
    localparam int WRITE_ONE_LOW_TIME_US = 6;
    localparam int READ_SETUP_TIME_US = 1;
    localparam int READ_SAMPLE_US = 12;
    localparam int RECOVERY_TIME_US = 5;

    localparam int RESET_LOW_CYC = RESET_LOW_TIME_US * CLK_MHZ;
    localparam int RESET_HIGH_CYC = RESET_HIGH_TIME_US * CLK_MHZ;
    localparam int PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_US * CLK_MHZ;
    localparam int SLOT_CYC = SLOT_LENGTH_US * CLK_MHZ;
    localparam int WRITE_ZERO_CYC = WRITE_ZERO_LOW_TIME_US * CLK_MHZ;
    localparam int WRITE_ONE_CYC = WRITE_ONE_LOW_TIME_US * CLK_MHZ;
    localparam int READ_SETUP_CYC = READ_SETUP_TIME_US * CLK_MHZ;
    localparam int READ_SAMPLE_CYC = READ_SAMPLE_US * CLK_MHZ;
    localparam int RECOVERY_CYC = RECOVERY_TIME_US * CLK_MHZ;

    // ************************************************************
    // commands and data
    // ************************************************************
    localparam int CNT_W = 17;
    localparam int FIFO_DEPTH = 8;
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [7:0] SKIP_IDENTITY_CMD = 8'hcc;
    localparam logic [7:0] CHECK_POLY = 8'h8c;
    localparam logic [7:0] CHECK_INIT = 8'h00;

endpackage : swm_pkg

// *** common/swm_stream_if.sv ***
`timescale 1ns/1ns
interface swm_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : swm_stream_if

// *** rtl/swm_fifo.sv ***
`timescale 1ns/1ns
module swm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // streams
    swm_stream_if.snk in_s,
    swm_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;
    logic not_full, next_not_full;

    // ready from a flop so the top-level ready is registered
    assign in_s.ready = not_full;
    assign out_s.valid = (count != '0);
    assign out_s.data = mem[rd_ptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        next_not_full = (next_count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            not_full <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            not_full <= next_not_full;
        end
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end
endmodule : swm_fifo

// *** rtl/swm_check_code.sv ***
`timescale 1ns/1ns
module swm_check_code (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic bit_valid,
    input wire logic bit_in,
    // result
    output logic [7:0] code
);
    import swm_pkg::*;

    logic [7:0] next_code;

    // lsb-first shift register, x^8+x^5+x^4+1
    always_comb begin
        next_code = code;
        if (clear) begin
            next_code = CHECK_INIT;
        end else if (bit_valid) begin
            next_code = {1'b0, code[7:1]} ^ ((code[0] ^ bit_in) ? CHECK_POLY : 8'h00);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            code <= CHECK_INIT;
        end else begin
            code <= next_code;
        end
    end
endmodule : swm_check_code

// *** rtl/swm_master.sv ***
`timescale 1ns/1ns
// Summary of operation
// - master starts every signal except presence
// - every transaction opens with reset, presence (the sequencer forces none: queued slots run with no reset before them)
// - reset drives line low 480 us
// - reset low plus rise under 960 us
// - master starts each slot by falling edge
// - slot 60-120 us, write-0 low >=60 us
// - read pulse <=1 us, sample before 15 us
// - wait reset-high 480 us after reset release
// - check code x^8+x^5+x^4+1 over received bits
module swm_master (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command stream: op[1:0], write bit
    input wire logic [2:0] cmd_data,
    input wire logic cmd_valid,
    output logic cmd_ready,
    // result stream: presence or read bit
    output logic res_data,
    output logic res_valid,
    input wire logic res_ready,
    // check code
    input wire logic check_clear,
    output logic [7:0] check_code,
    // status
    output logic busy,
    // single-wire line
    input wire logic line_in,
    output logic line_out,
    output logic line_oe
);
    import swm_pkg::*;

    typedef enum logic [2:0] {
        SWM_IDLE, SWM_RST_LOW, SWM_RST_HIGH, SWM_SLOT_LOW, SWM_SLOT_REST, SWM_RECOVER,
        SWM_PUSH
    } swm_state_e;

    // ************************************************************
    // line synchroniser
    // ************************************************************
    logic line_s1, line_s2;
    always_ff @(posedge clk) begin
        if (rst) begin
            line_s1 <= 1'b1;
            line_s2 <= 1'b1;
        end else begin
            line_s1 <= line_in;
            line_s2 <= line_s1;
        end
    end

    // ************************************************************
    // command fifo
    // ************************************************************
    swm_stream_if #(.W(3)) cmd_in ();
    swm_stream_if #(.W(3)) cmd_out ();
    assign cmd_in.valid = cmd_valid;
    assign cmd_in.data = cmd_data;
    assign cmd_ready = cmd_in.ready;

    swm_fifo #(.W(3), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_s(cmd_in),
        .out_s(cmd_out)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    swm_state_e state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [CNT_W-1:0] low_len, next_low_len;
    logic [1:0] op, next_op;
    logic sample, next_sample;
    logic next_line_oe, next_res_valid, next_res_data, next_busy;
    logic bit_valid;

    always_comb begin
        next_state = state;
        next_cnt = cnt + 1'b1;
        next_low_len = low_len;
        next_op = op;
        next_sample = sample;
        next_line_oe = line_oe;
        next_res_valid = res_valid;
        next_res_data = res_data;
        cmd_out.ready = 1'b0;
        bit_valid = 1'b0;
        if (res_valid && res_ready) begin
            next_res_valid = 1'b0;
        end
        unique case (state)
            SWM_IDLE: begin
                next_cnt = '0;
                if (cmd_out.valid) begin
                    cmd_out.ready = 1'b1;
                    next_op = cmd_out.data[1:0];
                    next_line_oe = 1'b1;
                    next_sample = 1'b1;
                    if (cmd_out.data[1:0] == OP_RESET) begin
                        next_state = SWM_RST_LOW;
                    end else begin
                        next_state = SWM_SLOT_LOW;
                        if (cmd_out.data[1:0] == OP_READ) begin
                            next_low_len = CNT_W'(READ_SETUP_CYC);
                        end else if (cmd_out.data[2]) begin
                            next_low_len = CNT_W'(WRITE_ONE_CYC);
                        end else begin
                            next_low_len = CNT_W'(WRITE_ZERO_CYC);
                        end
                    end
                end
            end
            SWM_RST_LOW: begin
                if (cnt == CNT_W'(RESET_LOW_CYC - 1)) begin
                    next_line_oe = 1'b0;
                    next_cnt = '0;
                    next_state = SWM_RST_HIGH;
                end
            end
            SWM_RST_HIGH: begin
                if (cnt == CNT_W'(PRESENCE_SAMPLE_CYC)) begin
                    next_sample = line_s2;
                end
                if (cnt == CNT_W'(RESET_HIGH_CYC - 1)) begin
                    next_state = SWM_PUSH;
                end
            end
            SWM_SLOT_LOW: begin
                if (cnt == low_len - 1'b1) begin
                    next_line_oe = 1'b0;
                    next_state = SWM_SLOT_REST;
                end
            end
            SWM_SLOT_REST: begin
                if (cnt == CNT_W'(READ_SAMPLE_CYC)) begin
                    next_sample = line_s2;
                end
                if (cnt == CNT_W'(SLOT_CYC - 1)) begin
                    next_cnt = '0;
                    next_state = SWM_RECOVER;
                end
            end
            SWM_RECOVER: begin
                if (cnt == CNT_W'(RECOVERY_CYC - 1)) begin
                    next_state = (op == OP_READ) ? SWM_PUSH : SWM_IDLE;
                end
            end
            SWM_PUSH: begin
                if (!res_valid || res_ready) begin
                    next_res_valid = 1'b1;
                    next_res_data = (op == OP_RESET) ? !sample : sample;
                    bit_valid = (op == OP_READ);
                    next_state = SWM_IDLE;
                end
            end
            default: begin
                next_state = SWM_IDLE;
            end
        endcase
        next_busy = (next_state != SWM_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SWM_IDLE;
            cnt <= '0;
            low_len <= '0;
            op <= OP_RESET;
            sample <= 1'b1;
            line_oe <= 1'b0;
            res_valid <= 1'b0;
            res_data <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            low_len <= next_low_len;
            op <= next_op;
            sample <= next_sample;
            line_oe <= next_line_oe;
            res_valid <= next_res_valid;
            res_data <= next_res_data;
            busy <= next_busy;
        end
    end

    // open drain: only ever drives low
    always_ff @(posedge clk) begin
        line_out <= 1'b0;
    end

    // ************************************************************
    // check code over read bits
    // ************************************************************
    swm_check_code u_check (
        .clk(clk),
        .rst(rst),
        .clear(check_clear),
        .bit_valid(bit_valid),
        .bit_in(next_res_data),
        .code(check_code)
    );
endmodule : swm_master

// *** verif/swm_master_sva.sv ***
`timescale 1ns/1ns
module swm_master_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // streams
    input wire logic [2:0] cmd_data,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic res_data,
    input wire logic res_valid,
    input wire logic res_ready,
    // check code and status
    input wire logic check_clear,
    input wire logic [7:0] check_code,
    input wire logic busy,
    // line
    input wire logic line_in,
    input wire logic line_out,
    input wire logic line_oe
);
    logic [16:0] hi;
    logic [16:0] gap;
    logic [16:0] last;
    // length of each low pulse and of each released gap
    always_ff @(posedge clk) begin
        if (rst) begin
            hi <= '0;
            gap <= '1;
            last <= '0;
        end else begin
            hi <= line_oe ? hi + 17'h1 : 17'h0;
            gap <= line_oe ? 17'h0 : (&gap ? gap : gap + 17'h1);
            if (!line_oe && hi != 17'h0) last <= hi;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_low_length: assert property ($fell(line_oe) |-> hi inside {125, 750, 7500, 60000})
        else $error("low pulse length wrong");
    a_reset_max: assert property (line_oe |-> hi < 120000)
        else $error("low pulse too long");
    a_recovery_gap: assert property ($rose(line_oe) |-> gap >= 125)
        else $error("recovery too short");
    a_reset_high: assert property ($rose(line_oe) && last == 60000 |-> gap >= 60000)
        else $error("reset high too short");
    a_slot_length: assert property ($rose(line_oe) |-> last + gap >= 7500)
        else $error("slot too short");
    a_drive_low: assert property (line_oe |-> line_out == 1'b0 && busy)
        else $error("line driven while idle or high");
    a_result_holds: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
        else $error("result dropped");
    a_clear_code: assert property (check_clear |=> check_code == 8'h00)
        else $error("check code not cleared");
    c_reset: cover property ($fell(line_oe) && hi == 60000);
    c_read0: cover property (res_valid && !res_data);
    c_full: cover property (!cmd_ready);
endmodule : swm_master_sva

// *** verif/swm_slave_model.sv ***
`timescale 1ns/1ns
module swm_slave_model (
    // bus line
    input wire logic line,
    output logic pull,
    // far-side state
    input wire logic selected,
    input wire logic pin_level,
    output logic last_bit
);
    import swm_pkg::*;
    time t_fall;
    logic [7:0] sreg;
    int nbits;
    logic muted;
    initial begin
        pull = 1'b0;
        last_bit = 1'b1;
        t_fall = 0;
        sreg = 8'h00;
        nbits = 0;
        muted = 1'b0;
    end
    // presence answer after a long low
    always @(posedge line) begin
        if (!pull && ($time - t_fall >= 480000)) begin
            nbits = 0;
            muted = 1'b0;
            #30000 pull = 1'b1;
            #120000 pull = 1'b0;
            t_fall = $time;
        end
    end
    // slot timed from the falling edge
    always @(negedge line) begin
        if (!pull) begin
            t_fall = $time;
            if (selected && !muted) begin
                pull = !pin_level;
                #30000 pull = 1'b0;
            end else begin
                #30000 last_bit = line;
                sreg = {last_bit, sreg[7:1]};
                nbits++;
                if (nbits == 8 && sreg == SKIP_IDENTITY_CMD) muted = 1'b1;
            end
        end
    end
endmodule : swm_slave_model

// *** verif/swm_master_test.sv ***
`timescale 1ns/1ns
module swm_master_test;
    import swm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] cmd_data = 3'h0;
    logic cmd_valid = 1'b0;
    logic res_ready = 1'b0;
    logic check_clear = 1'b0;
    logic sel = 1'b0;
    logic pin = 1'b0;
    logic cmd_ready, res_data, res_valid, busy, line_out, line_oe, pull, wbit;
    logic [7:0] check_code;
    logic [7:0] crc;
    wire line_in = !((line_oe && !line_out) || pull);
    int n_errors = 0;
    int checked = 0;
    int i, n;
    // last row: op code 3 acts as a write
    logic [2:0] r_cmd [5] = '{3'h2, 3'h2, 3'h1, 3'h5, 3'h7};
    logic r_pin [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic r_exp [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    swm_master dut (.*);
    swm_slave_model far (.line(line_in), .pull(pull), .selected(sel), .pin_level(pin),
        .last_bit(wbit));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // 0 result valid, 1 busy, 2 command ready
    task automatic await(input int w, input logic lvl);
        int k;
        for (k = 0; k < 200000; k++) begin
            #1;
            if ((w == 0 ? res_valid : w == 1 ? busy : cmd_ready) === lvl) return;
            @(posedge clk);
        end
        n_errors++;
        give_verdict();
    endtask : await
    task automatic send(input logic [2:0] c);
        cmd_data <= c;
        cmd_valid <= 1'b1;
        await(2, 1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : send
    task automatic take(input logic e);
        await(0, 1'b1);
        check("res_data", {7'h0, res_data}, {7'h0, e});
        @(posedge clk);
        res_ready <= 1'b1;
        @(posedge clk);
        res_ready <= 1'b0;
    endtask : take
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        return (c >> 1) ^ ((c[0] ^ b) ? CHECK_POLY : 8'h00);
    endfunction : crc_step
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        crc = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        send({1'b0, OP_RESET});
        take(1'b1);
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            sel <= (r_cmd[i][1:0] == OP_READ);
            pin <= r_pin[i];
            send(r_cmd[i]);
            if (r_cmd[i][1:0] == OP_READ) begin
                take(r_exp[i]);
                crc = crc_step(crc, r_exp[i]);
            end else begin
                await(1, 1'b1);
                await(1, 1'b0);
                check("written", {7'h0, wbit}, {7'h0, r_exp[i]});
            end
        end
        check("check_code", check_code, crc);
        @(posedge clk);
        check_clear <= 1'b1;
        @(posedge clk);
        check_clear <= 1'b0;
        @(posedge clk);
        #1;
        check("cleared", check_code, 8'h00);
        // fill the buffer with the sequencer busy
        @(posedge clk);
        pin <= 1'b1;
        sel <= 1'b1;
        cmd_data <= {1'b0, OP_READ};
        cmd_valid <= 1'b1;
        n = 0;
        for (i = 0; i < 12; i++) begin
            #1;
            n += int'(cmd_ready === 1'b1);
            @(posedge clk);
        end
        cmd_valid <= 1'b0;
        #1;
        check("full", {7'h0, cmd_ready}, 8'h00);
        check("accepted", 8'(n >= 8), 8'h01);
        // second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("line_oe", {7'h0, line_oe}, 8'h00);
        check("busy", {7'h0, busy}, 8'h00);
        check("flushed", {7'h0, cmd_ready}, 8'h01);
        check("code", check_code, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        give_verdict();
    end
endmodule : swm_master_test
bind swm_master swm_master_sva chk (.*);
